// ---- hdl/jtc_pin_sync.sv ----
`default_nettype none

// ****************************************************************
// two-flop synchroniser for the test pins, with clock edge pulses
// ****************************************************************
module jtc_pin_sync
  import jtc_pkg::*;
#(
  parameter int unsigned W = 4
) (
  input  wire logic         mclk,     // core clock
  input  wire logic         sys_rst,  // synchronous reset
  input  wire logic [W-1:0] pin_in,   // raw pins, bit 0 is the test clock
  output logic      [W-1:0] pin_out,  // synchronised pins
  output logic              rise,     // one-cycle pulse on test-clock rise
  output logic              fall      // one-cycle pulse on test-clock fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic         last_q;

  // first stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q[0];
    end
  end

  // mode select and data share the clock's delay, so they pair with its edge
  assign pin_out = sync_q;
  assign rise    = sync_q[0] & ~last_q;
  assign fall    = ~sync_q[0] & last_q;

endmodule : jtc_pin_sync

`default_nettype wire

// ---- hdl/jtc_pkg.sv ----
// How it works
// - five rising test-clock edges with mode select high always land in reset.
// - controller sits in reset from power-up, no test-clock activity needed.
// - state advances only on rising test-clock edges, steered by sampled mode select.
// - in reset all test logic is inactive and the device runs normally.
// - run-test/idle acts only when the current instruction asks; none here do.
// - capture-instruction loads a fixed pattern whose two low bits are 01.
// - shift-instruction moves the instruction path one stage per rising edge.
// - serial output changes only on falling test-clock edges.
// - update-instruction latches the shifted code on the falling edge as current.
// - capture-data loads the selected data register from its capture source.
// - data shift, exits, pause and update mirror the instruction path.
// - pause-instruction holds the instruction shift path unchanged.
// - select-data-scan chooses data path or select-instruction-scan from mode select.
// - select-instruction-scan chooses instruction path or reset from mode select.
// - first instruction exit goes to pause or update from mode select.
// - eight-bit instruction sets mode, operation, one of four registers, capture source.
// - bypass stage captures logic zero in capture-data.
// - codes 00 external test, 01 sample, 02 identification, 03 high-z, 08 clamp, 0F bypass; others private.
`default_nettype none

package jtc_pkg;

  // ****************************************************************
  // sizes and fixed values
  // ****************************************************************
  localparam int unsigned IR_W    = 8;
  localparam int unsigned ID_W    = 32;
  localparam int unsigned BSR_W   = 16;
  localparam int unsigned SYNC_W  = BSR_W + 3;

  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;  // low two bits must be 01
  localparam logic [IR_W-1:0] IR_EXTEST  = 8'h00;
  localparam logic [IR_W-1:0] IR_SAMPLE  = 8'h01;
  localparam logic [IR_W-1:0] IR_IDCODE  = 8'h02;
  localparam logic [IR_W-1:0] IR_HIGHZ   = 8'h03;
  localparam logic [IR_W-1:0] IR_CLAMP   = 8'h08;
  localparam logic [IR_W-1:0] IR_BYPASS  = 8'h0F;
  localparam logic [IR_W-1:0] IR_RESET   = IR_IDCODE;

  // identification word: arbitrary value, bit 0 set as scan rules demand
  localparam logic [ID_W-1:0]  IDCODE_VAL  = 32'h1000_2ABD;
  localparam logic [BSR_W-1:0] BSR_RESET   = 16'h0000;

  // pin positions in the synchroniser vector
  localparam int unsigned PIN_TCK = 0;
  localparam int unsigned PIN_TMS = 1;
  localparam int unsigned PIN_TDI = 2;
  localparam int unsigned PIN_CAP = 3;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } jtc_state_t;

  // the four scannable data registers
  typedef enum logic [1:0] {
    DR_BYPASS, DR_IDCODE, DR_BSR, DR_PRIVATE
  } jtc_dr_t;

endpackage : jtc_pkg

`default_nettype wire

// ---- hdl/jtc_tap.sv ----
`default_nettype none

// ****************************************************************
// test access port controller, instruction and data paths
// ****************************************************************
module jtc_tap
  import jtc_pkg::*;
(
  input  wire logic             mclk,         // core clock, 250 MHz
  input  wire logic             sys_rst,      // synchronous reset, also power-up
  input  wire logic             tck,          // test clock pin
  input  wire logic             tms,          // mode select pin
  input  wire logic             tdi,          // serial data in pin
  input  wire logic [BSR_W-1:0] bsr_cap,      // boundary pins to capture
  output logic                  tdo,          // serial data out
  output logic                  tdo_oe_n,     // low while serial out is driven
  output logic                  test_mode,    // normal function inhibited
  output logic                  outputs_hiz,  // device outputs disabled
  output logic [BSR_W-1:0]      bsr_drive,    // boundary values to drive
  output logic                  tap_in_reset  // controller in reset state
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [SYNC_W-1:0] pins;
  logic              tck_rise;
  logic              tck_fall;
  logic              tms_s;
  logic              tdi_s;
  logic [BSR_W-1:0]  cap_s;

  jtc_pin_sync #(
    .W (SYNC_W)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pin_in  ({bsr_cap, tdi, tms, tck}),
    .pin_out (pins),
    .rise    (tck_rise),
    .fall    (tck_fall)
  );

  // mode select and data ride the clock's delay, so they pair with its edges
  assign tms_s = pins[PIN_TMS];
  assign tdi_s = pins[PIN_TDI];
  assign cap_s = pins[PIN_CAP +: BSR_W];

  // ****************************************************************
  // helpers
  // ****************************************************************
  // true while test logic must keep its hands off the device
  function automatic logic is_reset(input jtc_state_t s);
    return s == ST_RESET;
  endfunction

  // a data register moves only on a rise while it is the selected one
  function automatic logic dr_turn(input logic rise_i, input jtc_dr_t sel_i, input jtc_dr_t own_i);
    return rise_i && sel_i == own_i;
  endfunction

  // update stages load on a fall while the controller sits in their update state
  function automatic logic upd_strobe(input logic fall_i, input jtc_state_t s, input jtc_state_t upd_i);
    return fall_i && s == upd_i;
  endfunction

  // next state from mode select; from any state five ones reach reset
  function automatic jtc_state_t next_state(input jtc_state_t s, input logic m);
    jtc_state_t n;
    n = s;
    case (s)
      ST_RESET:    n = m ? ST_RESET : ST_IDLE;
      ST_IDLE:     n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:   n = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR:   n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: n = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: n = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: n = m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR:   n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:   n = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR:   n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: n = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: n = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: n = m ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR:   n = m ? ST_SEL_DR : ST_IDLE;
      default:     n = ST_RESET;
    endcase
    return n;
  endfunction

  // ****************************************************************
  // state machine
  // ****************************************************************
  jtc_state_t state_q;
  jtc_state_t state_d;

  // the next state is offered every cycle but only taken on a detected rise
  always_comb begin
    state_d = next_state(state_q, tms_s);
  end

  // reset doubles as power-up, so no test-clock edge is needed to get there
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_RESET;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // instruction path
  // ****************************************************************
  logic [IR_W-1:0] ir_sr_q;
  logic [IR_W-1:0] ir_q;

  // shift stages: capture fixed pattern, shift, hold elsewhere incl. pause
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ir_sr_q <= IR_CAPTURE;
    end else if (is_reset(state_q)) begin
      ir_sr_q <= IR_CAPTURE;
    end else if (tck_rise) begin
      case (state_q)
        ST_CAP_IR:   ir_sr_q <= IR_CAPTURE;
        ST_SHIFT_IR: ir_sr_q <= {tdi_s, ir_sr_q[IR_W-1:1]};
        default:     ir_sr_q <= ir_sr_q;
      endcase
    end
  end

  // holding register: loaded on the falling edge, forced to default in reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ir_q <= IR_RESET;
    end else if (is_reset(state_q)) begin
      ir_q <= IR_RESET;
    end else if (upd_strobe(tck_fall, state_q, ST_UPD_IR)) begin
      ir_q <= ir_sr_q;
    end
  end

  // ****************************************************************
  // instruction decode
  // ****************************************************************
  jtc_dr_t dr_sel;
  logic    mode_test;
  logic    mode_hiz;
  logic    cap_pins;

  // unlisted codes are private; they scan a one-bit stage like bypass
  always_comb begin
    dr_sel    = DR_PRIVATE;
    mode_test = 1'b0;
    mode_hiz  = 1'b0;
    cap_pins  = 1'b0;
    case (ir_q)
      IR_EXTEST: begin
        dr_sel    = DR_BSR;
        mode_test = 1'b1;
        cap_pins  = 1'b1;
      end
      IR_SAMPLE: begin
        dr_sel   = DR_BSR;
        cap_pins = 1'b1;
      end
      IR_IDCODE: begin
        dr_sel = DR_IDCODE;
      end
      IR_HIGHZ: begin
        dr_sel    = DR_BYPASS;
        mode_test = 1'b1;
        mode_hiz  = 1'b1;
      end
      IR_CLAMP: begin
        dr_sel    = DR_BYPASS;
        mode_test = 1'b1;
      end
      IR_BYPASS: begin
        dr_sel = DR_BYPASS;
      end
      default: begin
        dr_sel = DR_PRIVATE;
      end
    endcase
  end

  // ****************************************************************
  // data registers
  // ****************************************************************
  logic             byp_q;
  logic             priv_q;
  logic [ID_W-1:0]  id_sr_q;
  logic [BSR_W-1:0] bsr_sr_q;

  // bypass stage: zero on capture, one stage of shift
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      byp_q <= 1'b0;
    end else if (is_reset(state_q)) begin
      byp_q <= 1'b0;
    end else if (dr_turn(tck_rise, dr_sel, DR_BYPASS)) begin
      case (state_q)
        ST_CAP_DR:   byp_q <= 1'b0;
        ST_SHIFT_DR: byp_q <= tdi_s;
        default:     byp_q <= byp_q;
      endcase
    end
  end

  // private stage behaves as bypass so unused codes keep the chain intact
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      priv_q <= 1'b0;
    end else if (is_reset(state_q)) begin
      priv_q <= 1'b0;
    end else if (dr_turn(tck_rise, dr_sel, DR_PRIVATE)) begin
      case (state_q)
        ST_CAP_DR:   priv_q <= 1'b0;
        ST_SHIFT_DR: priv_q <= tdi_s;
        default:     priv_q <= priv_q;
      endcase
    end
  end

  // identification shift register, read only
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      id_sr_q <= IDCODE_VAL;
    end else if (is_reset(state_q)) begin
      id_sr_q <= IDCODE_VAL;
    end else if (dr_turn(tck_rise, dr_sel, DR_IDCODE)) begin
      case (state_q)
        ST_CAP_DR:   id_sr_q <= IDCODE_VAL;
        ST_SHIFT_DR: id_sr_q <= {tdi_s, id_sr_q[ID_W-1:1]};
        default:     id_sr_q <= id_sr_q;
      endcase
    end
  end

  // boundary shift register; captures pins or keeps value per instruction
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bsr_sr_q <= BSR_RESET;
    end else if (is_reset(state_q)) begin
      bsr_sr_q <= BSR_RESET;
    end else if (dr_turn(tck_rise, dr_sel, DR_BSR)) begin
      case (state_q)
        ST_CAP_DR:   bsr_sr_q <= cap_pins ? cap_s : bsr_sr_q;
        ST_SHIFT_DR: bsr_sr_q <= {tdi_s, bsr_sr_q[BSR_W-1:1]};
        default:     bsr_sr_q <= bsr_sr_q;
      endcase
    end
  end

  // boundary update stage on the falling edge, cleared in reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bsr_drive <= BSR_RESET;
    end else if (is_reset(state_q)) begin
      bsr_drive <= BSR_RESET;
    end else if (upd_strobe(tck_fall, state_q, ST_UPD_DR) && dr_sel == DR_BSR) begin
      bsr_drive <= bsr_sr_q;
    end
  end

  // ****************************************************************
  // serial output
  // ****************************************************************
  logic dr_bit;

  // serial bit of whichever data register the instruction selects
  always_comb begin
    case (dr_sel)
      DR_BYPASS: dr_bit = byp_q;
      DR_IDCODE: dr_bit = id_sr_q[0];
      DR_BSR:    dr_bit = bsr_sr_q[0];
      default:   dr_bit = priv_q;
    endcase
  end

  // moves only on falling edges so the tester samples a settled bit
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tdo <= 1'b0;
    end else if (tck_fall) begin
      case (state_q)
        ST_SHIFT_IR: tdo <= ir_sr_q[0];
        ST_SHIFT_DR: tdo <= dr_bit;
        default:     tdo <= tdo;
      endcase
    end
  end

  // enable follows the same falls; a released pin keeps the last bit behind it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      case (state_q)
        ST_SHIFT_IR: tdo_oe_n <= 1'b0;
        ST_SHIFT_DR: tdo_oe_n <= 1'b0;
        default:     tdo_oe_n <= 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // mode outputs
  // ****************************************************************
  // idle state triggers nothing: no instruction here runs a self test
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      test_mode <= 1'b0;
    end else begin
      test_mode <= mode_test && !is_reset(state_q);
    end
  end

  // outputs float only under the high-impedance code, never in reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      outputs_hiz <= 1'b0;
    end else begin
      outputs_hiz <= mode_hiz && !is_reset(state_q);
    end
  end

  // reset flag trails the state by one cycle, like test_mode and outputs_hiz
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tap_in_reset <= 1'b1;
    end else begin
      tap_in_reset <= is_reset(state_q);
    end
  end

endmodule : jtc_tap

`default_nettype wire

// ---- verif/jtc_tap_checker.sv ----
`default_nettype none

// ********
// port checker for the test access port
// ********
module jtc_tap_checker
  import jtc_pkg::*;
(
  input wire logic             mclk,        // core clock
  input wire logic             sys_rst,     // sync reset
  input wire logic             tck,         // test clock pin
  input wire logic             tms,         // mode select pin
  input wire logic             tdi,         // serial in pin
  input wire logic [BSR_W-1:0] bsr_cap,     // boundary capture
  input wire logic             tdo,         // serial out
  input wire logic             tdo_oe_n,    // serial out enable
  input wire logic             test_mode,   // normal function held
  input wire logic             outputs_hiz, // outputs disabled
  input wire logic [BSR_W-1:0] bsr_drive,   // boundary update stage
  input wire logic             tap_in_reset // reset state flag
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  logic       tck_q;
  logic [3:0] lo_cnt_q;
  logic [3:0] hi_cnt_q;
  logic [2:0] ones_q;

  // previous pin level, to find rises
  always_ff @(posedge mclk) begin
    tck_q <= tck;
  end
  // samples since the pin went low; saturates so long idles stay cheap
  always_ff @(posedge mclk) begin
    lo_cnt_q <= tck ? 4'h0 : (lo_cnt_q == 4'hF ? 4'hF : lo_cnt_q + 4'h1);
  end
  // samples since the pin went high
  always_ff @(posedge mclk) begin
    hi_cnt_q <= !tck ? 4'h0 : (hi_cnt_q == 4'hF ? 4'hF : hi_cnt_q + 4'h1);
  end
  // run of rises with mode select high
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ones_q <= 3'h0;
    end else if (tck && !tck_q) begin
      ones_q <= !tms ? 3'h0 : (ones_q == 3'h5 ? 3'h5 : ones_q + 3'h1);
    end
  end

  reset_values_a: assert property (@(posedge mclk) disable iff (1'b0) sys_rst |=>
    tap_in_reset && tdo_oe_n && !test_mode && !outputs_hiz && tdo == 1'b0 && bsr_drive == 16'h0000)
    else $error("outputs wrong during reset");
  tdo_fall_a: assert property ($changed(tdo) |-> !tck && lo_cnt_q inside {[4'h1:4'h7]})
    else $error("serial out moved away from a test-clock fall");
  oe_fall_a: assert property ($changed(tdo_oe_n) |-> !tck && lo_cnt_q inside {[4'h1:4'h7]})
    else $error("serial out enable moved away from a test-clock fall");
  bsr_update_a: assert property ($changed(bsr_drive) && bsr_drive != 16'h0000 |->
    !tck && lo_cnt_q inside {[4'h1:4'h7]}) else $error("boundary update off a test-clock fall");
  reset_quiet_a: assert property (tap_in_reset && $past(tap_in_reset, 2) |->
    !test_mode && !outputs_hiz && bsr_drive == 16'h0000) else $error("test logic active in reset");
  hiz_test_a: assert property (outputs_hiz |-> test_mode)
    else $error("outputs disabled outside test mode");
  state_rise_a: assert property ($changed(tap_in_reset) |-> tck && hi_cnt_q inside {[4'h1:4'h7]})
    else $error("state moved away from a test-clock rise");
  five_ones_a: assert property (tck && !tck_q && tms && ones_q == 3'h4 |-> ##[1:12] tap_in_reset)
    else $error("five high mode selects did not reach reset");
  shift_live_a: assert property (!tdo_oe_n |-> !tap_in_reset)
    else $error("serial out driven in reset state");

  cover property (!tdo_oe_n);
  cover property ($rose(test_mode));
  cover property ($rose(outputs_hiz));
endmodule // jtc_tap_checker

bind jtc_tap jtc_tap_checker u_jtc_tap_checker (.mclk, .sys_rst, .tck, .tms, .tdi, .bsr_cap, .tdo,
  .tdo_oe_n, .test_mode, .outputs_hiz, .bsr_drive, .tap_in_reset);

`default_nettype wire

// ---- verif/jtc_tester.sv ----
`default_nettype none

// ********
// boundary-scan tester: test clock 80 ns, stands low between steps
// ********
module jtc_tester (
  input  wire logic mclk, // core clock
  input  wire logic tdo,  // serial out
  output var  logic tck,  // test clock
  output var  logic tms,  // mode select
  output var  logic tdi   // serial in
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle levels at time zero
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one period: set up, sample serial out late in the low phase, rise, fall
  task automatic step(input logic m, input logic d, output logic o);
    @(negedge mclk);
    tms = m;
    tdi = d;
    repeat (6) @(negedge mclk);
    o = tdo;
    repeat (3) @(negedge mclk);
    tck = 1'b1;
    repeat (10) @(negedge mclk);
    tck = 1'b0;
  endtask

  // walk the state graph, mode bits lsb first; serial in toggles as junk
  task automatic path(input logic [7:0] m, input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      step(m[i], ~tdi, o);
    end
  endtask

  // shift n bits lsb first, the last one leaving for exit1
  task automatic scan(input logic [31:0] din, input int n, output logic [31:0] dout);
    dout = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
  endtask
endmodule // jtc_tester

`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none

`define CHK(a, b) begin \
  comparisons++; \
  if ((a) !== (b)) begin \
    failures++; \
    $display("Error t=%0t got %0h exp %0h", $time, (a), (b)); \
  end \
end

// ********
// testbench top
// ********
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import jtc_pkg::*;

  logic             mclk, sys_rst, tck, tms, tdi;
  logic             tdo, tdo_oe_n, test_mode, outputs_hiz, tap_in_reset;
  logic [BSR_W-1:0] bsr_cap, bsr_drive;
  int               failures = 0;
  int               comparisons = 0;

  jtc_tap u_jtc_tap (.mclk, .sys_rst, .tck, .tms, .tdi, .bsr_cap, .tdo, .tdo_oe_n,
    .test_mode, .outputs_hiz, .bsr_drive, .tap_in_reset);
  jtc_tester u_jtc_tester (.mclk, .tdo, .tck, .tms, .tdi);

  // core clock, 4 ns
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // instruction scan from idle back to idle; returns the captured pattern
  task automatic load_ir(input logic [7:0] code, output logic [31:0] d);
    u_jtc_tester.path(8'h03, 4);
    u_jtc_tester.scan({24'h0, code}, 8, d);
    u_jtc_tester.path(8'h01, 2);
  endtask

  // identification read straight out of reset
  task automatic t_idcode();
    logic [31:0] d;
    `CHK(tap_in_reset, 1'b1)
    u_jtc_tester.path(8'h02, 4);
    u_jtc_tester.scan(32'h0, 32, d);
    `CHK(d, IDCODE_VAL)
    u_jtc_tester.path(8'h01, 2);
  endtask

  // instruction shift split by a pause; contents must survive it
  task automatic t_ir_pause();
    logic [31:0] a, b;
    u_jtc_tester.path(8'h03, 4);
    u_jtc_tester.scan(32'hF, 4, a);
    u_jtc_tester.path(8'h04, 4);
    u_jtc_tester.scan(32'h0, 4, b);
    `CHK({b[3:0], a[3:0]}, IR_CAPTURE)
    u_jtc_tester.path(8'h01, 2);
    `CHK(test_mode, 1'b0)
  endtask

  // bypass stage: zero first, then serial in one stage late
  task automatic t_bypass();
    logic [31:0] d;
    u_jtc_tester.path(8'h01, 3);
    u_jtc_tester.scan(32'hB5, 8, d);
    `CHK(d[7:0], 8'h6A)
    u_jtc_tester.path(8'h01, 2);
  endtask

  // every listed code, with its mode flags
  task automatic t_codes();
    logic [7:0]  codes [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h0F};
    logic [0:5]  tm_exp = 6'b100110;
    logic [0:5]  hz_exp = 6'b000100;
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      load_ir(codes[i], d);
      `CHK(d[7:0], IR_CAPTURE)
      `CHK(test_mode, tm_exp[i])
      `CHK(outputs_hiz, hz_exp[i])
    end
  endtask

  // preload under sample, then drive it under external test
  task automatic t_bsr();
    logic [31:0] d;
    load_ir(IR_SAMPLE, d);
    u_jtc_tester.path(8'h01, 3);
    u_jtc_tester.scan(32'h5A3C, 16, d);
    `CHK(d[15:0], 16'hA5C3)
    u_jtc_tester.path(8'h01, 2);
    `CHK(bsr_drive, 16'h5A3C)
    `CHK(test_mode, 1'b0)
    load_ir(IR_EXTEST, d);
    `CHK(test_mode, 1'b1)
    `CHK(bsr_drive, 16'h5A3C)
  endtask

  // four high mode selects from shift-data stop short, the fifth resets
  task automatic t_five();
    u_jtc_tester.path(8'h01, 3);
    u_jtc_tester.path(8'h0F, 4);
    `CHK(tap_in_reset, 1'b0)
    u_jtc_tester.path(8'h01, 1);
    `CHK(tap_in_reset, 1'b1)
    `CHK(test_mode, 1'b0)
    `CHK(bsr_drive, 16'h0000)
  endtask

  // verdict and end of run
  task automatic summarize();
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // main sequence; tck stays low through reset release
  initial begin
    sys_rst = 1'b1;
    bsr_cap = 16'hA5C3;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    t_idcode();
    t_ir_pause();
    t_bypass();
    t_codes();
    t_bsr();
    t_five();
    summarize();
  end

  // watchdog, about six times the expected run
  initial begin
    #100000;
    failures++;
    summarize();
  end
endmodule // tb

`default_nettype wire
